/* File: hw/rfdc_pkg.sv */
// Purpose: Constants shared by the direct command decoder files
// Assumes: 32-bit AHB-Lite register bus, byte addresses
// Notes:   Action indices select one bit of the action pulse vector
package rfdc_pkg;
    // Mode bits that mark a direct command byte
    localparam logic [1:0]  MODE_DIRECT = 2'b11;
    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_LASTCMD = 8'h08;
    localparam logic [7:0]  OFS_ADC     = 8'h0c;
    // Control register fields
    localparam int          CTRL_W      = 5;
    localparam int          B_EN        = 0;
    localparam int          B_TX        = 1;
    localparam int          B_RX        = 2;
    localparam int          B_ISOA      = 3;
    localparam int          B_WU        = 4;
    localparam logic [4:0]  CTRL_RST    = 5'h00;
    // Status register fields
    localparam int          S_REJ       = 0;
    localparam int          S_TEST      = 1;
    localparam int          S_SPB       = 2;
    localparam int          S_TRANSP    = 3;
    localparam int          S_AM        = 4;
    localparam int          S_MASK      = 5;
    localparam int          S_SLEEP     = 6;
    localparam int          S_BUSY      = 7;
    // Enable requirement bits of a command
    localparam int          N_EN        = 0;
    localparam int          N_TX        = 1;
    localparam int          N_RX        = 2;
    localparam int          N_ISOA      = 3;
    localparam int          N_NOTWU     = 4;
    // Action indices
    localparam int          NACT        = 31;
    localparam logic [4:0]  A_DEF       = 5'h00;
    localparam logic [4:0]  A_STOP      = 5'h01;
    localparam logic [4:0]  A_TXC       = 5'h02;
    localparam logic [4:0]  A_TXN       = 5'h03;
    localparam logic [4:0]  A_REQA      = 5'h04;
    localparam logic [4:0]  A_WUPA      = 5'h05;
    localparam logic [4:0]  A_FI        = 5'h06;
    localparam logic [4:0]  A_FR        = 5'h07;
    localparam logic [4:0]  A_SENSE     = 5'h08;
    localparam logic [4:0]  A_SLEEP     = 5'h09;
    localparam logic [4:0]  A_MASK      = 5'h0a;
    localparam logic [4:0]  A_UNMASK    = 5'h0b;
    localparam logic [4:0]  A_AM        = 5'h0c;
    localparam logic [4:0]  A_MAMP      = 5'h0d;
    localparam logic [4:0]  A_GAIN      = 5'h0e;
    localparam logic [4:0]  A_REG       = 5'h0f;
    localparam logic [4:0]  A_DRV       = 5'h10;
    localparam logic [4:0]  A_MPH       = 5'h11;
    localparam logic [4:0]  A_RSSI      = 5'h12;
    localparam logic [4:0]  A_FIFO      = 5'h13;
    localparam logic [4:0]  A_TRANSP    = 5'h14;
    localparam logic [4:0]  A_MSUP      = 5'h15;
    localparam logic [4:0]  A_GPT       = 5'h16;
    localparam logic [4:0]  A_WUT       = 5'h17;
    localparam logic [4:0]  A_MRT       = 5'h18;
    localparam logic [4:0]  A_NRT       = 5'h19;
    localparam logic [4:0]  A_PPON      = 5'h1a;
    localparam logic [4:0]  A_NRTSTOP   = 5'h1b;
    localparam logic [4:0]  A_RCCAL     = 5'h1c;
    localparam logic [4:0]  A_SPB       = 5'h1d;
    localparam logic [4:0]  A_TEST      = 5'h1e;
endpackage : rfdc_pkg

/* File: hw/rfdc_sync.sv */
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Single destination clock
// Notes:   Only the second stage leaves; both stages reset to the idle high
`timescale 1ns/1ps
module rfdc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '1;
            q        <= '1;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : rfdc_sync

/* File: hw/rfdc_top.sv */
// Purpose: Direct command decoder and dispatcher with AHB-Lite registers
// Assumes: Serial front end delivers each mode byte as a one-cycle strobe
// Notes:   Actions leave as one-hot pulses on act_pulse
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
// How it works
// - C0/C1 restore power-up state in any mode; not chained, no irq.
// - C2/C3 with master enable halt tx, rx, commands, timers.
// - C4 with master enable starts transmission with CRC.
// - C5 with master enable starts transmission without CRC.
// - C6/C7 send REQA/WUPA; need ISO-A mode, master and tx enable.
// - C8 does initial collision avoidance, field on, irq at end.
// - C9 does response collision avoidance, field on, irq at end.
// - CD with master and rx enable puts target in Sense state.
// - CE with master and rx enable puts target in Sleep state.
// - D0 in any mode masks receivers and decoders.
// - D1 in any mode unmasks receivers and decoders.
// - D2 with master and tx enable toggles AM state.
// - D3 measures amplitude into converter register, irq at end.
// - D5 reloads receiver gain from fourth receiver setting.
// - D6 trims supply regulators, irq at end.
// - D8 runs driver timing calibration, no irq.
// - D9 measures phase in any mode, irq at end.
// - DA zeroes signal strength result and restarts measuring.
// - DC enters transparent mode, not chained.
// - E2 starts receive-mask timer and squelch.
// - FB opens secondary register space access when another byte follows it in the frame.
// - FC opens test register access when another byte follows it in the frame.
// - Execution starts on rising edge of the select line, or for a chainable code when the next mode byte follows.
module rfdc_top
    import rfdc_pkg::*;
#(
    parameter int ADC_W = 8
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [7:0]        haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              serial_select_line,
    input  wire logic              mode_valid,
    input  wire logic [7:0]        mode_byte,
    input  wire logic              op_done,
    input  wire logic [ADC_W-1:0]  meas_result,
    output logic      [NACT-1:0]   act_pulse,
    output logic                   cmd_irq,
    output logic                   busy,
    output logic                   rx_masked,
    output logic                   am_on,
    output logic                   tgt_sleep,
    output logic                   transparent,
    output logic                   space_b_open,
    output logic                   test_open
);
    logic              sel_s;
    logic              sel_q;
    logic              sel_rise;
    logic              sel_fall;
    logic              pend_reg;
    logic [7:0]        pend_op_reg;
    logic [12:0]       dec;
    logic              dec_ok;
    logic              dec_chain;
    logic              dec_irq;
    logic [4:0]        dec_need;
    logic [4:0]        act;
    logic              exec_req;
    logic              drop;
    logic              need_ok;
    logic              go;
    logic [CTRL_W-1:0] ctrl_reg;
    logic [4:0]        busy_act_reg;
    logic [7:0]        last_op_reg;
    logic              rej_reg;
    logic [ADC_W-1:0]  adc_reg;
    logic              wr_pend_reg;
    logic [7:0]        wr_addr_reg;
    logic              addr_ph;
    logic [31:0]       rd_mux;

    rfdc_sync #(.W(1)) u_sel_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     (serial_select_line),
        .q     (sel_s)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q <= 1'b1;
        end else begin
            sel_q <= sel_s;
        end
    end

    assign sel_rise = sel_s & ~sel_q;
    assign sel_fall = ~sel_s & sel_q;

    // Table: {defined, chainable, irq at end, needs, action}
    function automatic logic [12:0] decode(input logic [7:0] op);
        case (op)
            8'hc0, 8'hc1: decode = {3'b100, 5'h00, A_DEF};
            8'hc2, 8'hc3: decode = {3'b110, 5'h01, A_STOP};
            8'hc4:        decode = {3'b110, 5'h01, A_TXC};
            8'hc5:        decode = {3'b110, 5'h01, A_TXN};
            8'hc6:        decode = {3'b110, 5'h0b, A_REQA};
            8'hc7:        decode = {3'b110, 5'h0b, A_WUPA};
            8'hc8:        decode = {3'b111, 5'h01, A_FI};
            8'hc9:        decode = {3'b111, 5'h01, A_FR};
            8'hcd:        decode = {3'b110, 5'h05, A_SENSE};
            8'hce:        decode = {3'b110, 5'h05, A_SLEEP};
            8'hd0:        decode = {3'b110, 5'h00, A_MASK};
            8'hd1:        decode = {3'b110, 5'h00, A_UNMASK};
            8'hd2:        decode = {3'b110, 5'h03, A_AM};
            8'hd3:        decode = {3'b101, 5'h00, A_MAMP};
            8'hd5:        decode = {3'b100, 5'h01, A_GAIN};
            8'hd6:        decode = {3'b101, 5'h01, A_REG};
            8'hd8:        decode = {3'b100, 5'h01, A_DRV};
            8'hd9:        decode = {3'b101, 5'h00, A_MPH};
            8'hda:        decode = {3'b110, 5'h01, A_RSSI};
            8'hdb:        decode = {3'b110, 5'h01, A_FIFO};
            8'hdc:        decode = {3'b100, 5'h01, A_TRANSP};
            8'hdf:        decode = {3'b101, 5'h01, A_MSUP};
            8'he0:        decode = {3'b110, 5'h01, A_GPT};
            8'he1:        decode = {3'b110, 5'h10, A_WUT};
            8'he2:        decode = {3'b110, 5'h01, A_MRT};
            8'he3:        decode = {3'b110, 5'h01, A_NRT};
            8'he4:        decode = {3'b110, 5'h01, A_PPON};
            8'he8:        decode = {3'b110, 5'h01, A_NRTSTOP};
            8'hea:        decode = {3'b101, 5'h01, A_RCCAL};
            8'hfb:        decode = {3'b110, 5'h00, A_SPB};
            8'hfc:        decode = {3'b110, 5'h00, A_TEST};
            default:      decode = 13'h0000;
        endcase
    endfunction : decode

    assign dec       = decode(pend_op_reg);
    assign dec_ok    = dec[12];
    assign dec_chain = dec[11];
    assign dec_irq   = dec[10];
    assign dec_need  = dec[9:5];
    assign act       = dec[4:0];

    // A chainable command runs as soon as the next mode byte follows it
    assign exec_req = pend_reg & (sel_rise | (mode_valid & dec_chain));
    assign drop     = pend_reg & mode_valid & ~dec_chain & ~sel_rise;
    assign need_ok  = (~dec_need[N_EN]    | ctrl_reg[B_EN])
                    & (~dec_need[N_TX]    | ctrl_reg[B_TX])
                    & (~dec_need[N_RX]    | ctrl_reg[B_RX])
                    & (~dec_need[N_ISOA]  | ctrl_reg[B_ISOA])
                    & (~dec_need[N_NOTWU] | ~ctrl_reg[B_WU]);
    // A running long command only yields to default or stop
    assign go = exec_req & dec_ok & need_ok
              & (~busy | act == A_DEF | act == A_STOP);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_reg    <= 1'b0;
            pend_op_reg <= 8'h00;
        end else begin
            if (exec_req || drop) begin
                pend_reg <= 1'b0;
            end
            if (mode_valid && mode_byte[7:6] == MODE_DIRECT) begin
                pend_reg    <= 1'b1;
                pend_op_reg <= mode_byte;
            end
        end
    end

    // One-hot action strobe for the rest of the reader
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_pulse <= '0;
        end else if (go) begin
            act_pulse <= {{(NACT-1){1'b0}}, 1'b1} << act;
        end else begin
            act_pulse <= '0;
        end
    end

    // Long commands hold busy until the worker reports completion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy         <= 1'b0;
            busy_act_reg <= A_DEF;
            cmd_irq      <= 1'b0;
        end else begin
            cmd_irq <= busy & op_done;
            if (go && (act == A_DEF || act == A_STOP)) begin
                busy    <= 1'b0;
                cmd_irq <= 1'b0;
            end else if (go && dec_irq) begin
                busy         <= 1'b1;
                busy_act_reg <= act;
            end else if (op_done) begin
                busy <= 1'b0;
            end
        end
    end

    // Receiver, modulation and target levels
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_masked <= 1'b0;
            am_on     <= 1'b0;
            tgt_sleep <= 1'b0;
        end else if (go) begin
            case (act)
                A_DEF: begin
                    rx_masked <= 1'b0;
                    am_on     <= 1'b0;
                    tgt_sleep <= 1'b0;
                end
                A_MASK:   rx_masked <= 1'b1;
                A_UNMASK: rx_masked <= 1'b0;
                A_AM:     am_on     <= ~am_on;
                A_SENSE:  tgt_sleep <= 1'b0;
                A_SLEEP:  tgt_sleep <= 1'b1;
                default:  rx_masked <= rx_masked;
            endcase
        end
    end

    // Access windows close with the frame; transparent ends on select low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            space_b_open <= 1'b0;
            test_open    <= 1'b0;
            transparent  <= 1'b0;
        end else begin
            if (sel_rise || (go && act == A_DEF)) begin
                space_b_open <= 1'b0;
                test_open    <= 1'b0;
            end else if (go && act == A_SPB) begin
                space_b_open <= 1'b1;
            end else if (go && act == A_TEST) begin
                test_open <= 1'b1;
            end
            if (go && act == A_TRANSP) begin
                transparent <= 1'b1;
            end else if (sel_fall || (go && act == A_DEF)) begin
                transparent <= 1'b0;
            end
        end
    end

    // Converter result and last command record
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adc_reg     <= '0;
            last_op_reg <= 8'h00;
            rej_reg     <= 1'b0;
        end else begin
            if (go && act == A_DEF) begin
                adc_reg <= '0;
            end else if (busy && op_done && (busy_act_reg == A_MAMP
                         || busy_act_reg == A_MPH
                         || busy_act_reg == A_MSUP)) begin
                adc_reg <= meas_result;
            end
            if (exec_req && dec_ok) begin
                last_op_reg <= pend_op_reg;
                rej_reg     <= ~go;
            end
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    assign addr_ph = hsel & htrans[1] & hready;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr)
            OFS_CTRL:    rd_mux[CTRL_W-1:0] =
                (wr_pend_reg && wr_addr_reg == OFS_CTRL)
                ? hwdata[CTRL_W-1:0] : ctrl_reg;
            OFS_STATUS:  rd_mux[7:0] = {busy, tgt_sleep, rx_masked,
                am_on, transparent, space_b_open, test_open, rej_reg};
            OFS_LASTCMD: rd_mux[7:0] = last_op_reg;
            OFS_ADC:     rd_mux[ADC_W-1:0] = adc_reg;
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            wr_pend_reg <= addr_ph & hwrite;
            if (addr_ph) begin
                wr_addr_reg <= haddr;
            end
            if (addr_ph && !hwrite) begin
                hrdata <= rd_mux;
            end
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Set default wins over a software write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RST;
        end else if (go && act == A_DEF) begin
            ctrl_reg <= CTRL_RST;
        end else if (wr_pend_reg && wr_addr_reg == OFS_CTRL) begin
            ctrl_reg <= hwdata[CTRL_W-1:0];
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_go(logic [4:0] a);
        go && act == a;
    endsequence
    sequence s_long_done;
        busy && op_done && !go;
    endsequence

    a_default_restores: assert property (s_go(A_DEF) |=>
        !busy && !rx_masked && ctrl_reg == CTRL_RST && !cmd_irq)
        else $error("set default did not restore power-up state");
    a_stop_needs_en: assert property (exec_req && dec_ok &&
        act == A_STOP && !ctrl_reg[B_EN] |=> act_pulse == '0)
        else $error("stop ran without master enable");
    a_tx_crc_pulse: assert property (exec_req &&
        pend_op_reg == 8'hc4 && ctrl_reg[B_EN] && !busy
        |=> act_pulse[A_TXC] ##1 !act_pulse[A_TXC])
        else $error("transmit with crc strobe wrong");
    a_reqa_gated: assert property ($rose(act_pulse[A_REQA])
        |-> $past(ctrl_reg[B_EN] && ctrl_reg[B_TX] && ctrl_reg[B_ISOA]))
        else $error("reqa sent without required enables");
    a_field_irq: assert property ((s_long_done
        and busy_act_reg == A_FI) |=> cmd_irq ##1 !cmd_irq)
        else $error("field on completion irq missing");
    a_sleep_state: assert property (s_go(A_SLEEP) |=>
        tgt_sleep && act_pulse[A_SLEEP])
        else $error("sleep state not entered");
    a_mask_rx: assert property (s_go(A_MASK) |=> rx_masked)
        else $error("receivers not masked");
    a_am_toggle: assert property (s_go(A_AM) |=>
        am_on != $past(am_on))
        else $error("am state did not toggle");
    a_amp_result: assert property ((s_long_done
        and busy_act_reg == A_MAMP) |=> adc_reg == $past(meas_result))
        else $error("amplitude result not stored");
    a_undef_ignored: assert property (exec_req && !dec_ok
        |=> act_pulse == '0 && $stable(ctrl_reg) && !cmd_irq)
        else $error("undefined opcode had an effect");
    a_spb_open: assert property ((s_go(A_SPB) and !sel_rise)
        |=> space_b_open)
        else $error("space b access not opened");
endmodule : rfdc_top

/* File: verification/rfdc_host.sv */
// Purpose: Host model that frames direct command bytes
// Assumes: Select idles high and stays low for the whole frame
// Notes:   The bench calls frame; a second code follows in the frame when two is set
`timescale 1ns/1ps
module rfdc_host (
    input  wire logic       clk,
    output logic            serial_select_line,
    output logic            mode_valid,
    output logic [7:0]      mode_byte
);
    initial begin
        serial_select_line = 1'b1;
        mode_valid         = 1'b0;
        mode_byte          = 8'h3c;
    end

    // Byte line shows the inverse once the byte has gone
    task automatic send(input logic [5:0] c);
        mode_valid <= 1'b1;
        mode_byte  <= {2'b11, c};
        @(posedge clk);
        mode_valid <= 1'b0;
        mode_byte  <= ~{2'b11, c};
    endtask : send

    task automatic frame(input logic [5:0] a, input logic [5:0] b,
                         input bit two);
        serial_select_line <= 1'b0;
        @(posedge clk);
        send(a);
        if (two) begin
            @(posedge clk);
            send(b);
        end
        serial_select_line <= 1'b1;
    endtask : frame
endmodule : rfdc_host

/* File: verification/rfdc_top_test.sv */
// Purpose: Self-checking bench for the direct command decoder
// Assumes: Registers at 0x00..0x0c, zero wait AHB-Lite slave
// Notes:   A monitor queues every action pulse and counts irq pulses
`timescale 1ns/1ps
module rfdc_top_test
    import rfdc_pkg::*;
;
    logic             hclk, hresetn, hsel, hwrite, hready, hresp, op_done;
    logic [7:0]       haddr, mode_byte, meas_result;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic [31:0]      hwdata, hrdata, d;
    logic             hreadyout, sel, mode_valid, cmd_irq, busy;
    logic             rx_masked, am_on, tgt_sleep, transparent;
    logic             space_b_open, test_open;
    logic [NACT-1:0]  act_pulse;
    logic [NACT-1:0]  seen[$];
    int               num_errors, comparisons, irq_n;
    logic [5:0]       cc[15] = '{6'h02, 6'h04, 6'h05, 6'h06, 6'h07, 6'h0d,
        6'h0e, 6'h12, 6'h15, 6'h18, 6'h1a, 6'h22, 6'h3b, 6'h3c, 6'h1c};
    int               ca[15] = '{1, 2, 3, 4, 5, 8, 9, 12, 14, 16, 18, 24,
        29, 30, 20};
    logic [5:0]       lc[5] = '{6'h08, 6'h09, 6'h13, 6'h16, 6'h19};
    int               la[5] = '{6, 7, 13, 15, 17};

    assign hready = hreadyout;
    rfdc_top i_rfdc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .serial_select_line(sel),
        .mode_valid(mode_valid), .mode_byte(mode_byte), .op_done(op_done),
        .meas_result(meas_result), .act_pulse(act_pulse), .cmd_irq(cmd_irq),
        .busy(busy), .rx_masked(rx_masked), .am_on(am_on),
        .tgt_sleep(tgt_sleep), .transparent(transparent),
        .space_b_open(space_b_open), .test_open(test_open));
    rfdc_host i_rfdc_host (.clk(hclk), .serial_select_line(sel),
        .mode_valid(mode_valid), .mode_byte(mode_byte));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        if (act_pulse !== '0) seen.push_back(act_pulse);
        if (cmd_irq === 1'b1) irq_n++;
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic ahb(input logic [7:0] a, input logic w,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : ahb

    task automatic rd(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
        ahb(a, 1'b0, 32'h0);
        chk(what, exp, d);
        chk("hresp", 0, hresp);
    endtask : rd

    // One command frame; idx below zero means no action may appear
    task automatic run(input logic [5:0] c, input int idx);
        seen.delete();
        i_rfdc_host.frame(c, 6'h00, 1'b0);
        repeat (8) @(posedge hclk);
        chk("pulse count", (idx < 0) ? 0 : 1, seen.size());
        if (idx >= 0 && seen.size() > 0) chk("act", 32'(1) << idx, seen[0]);
    endtask : run

    task automatic done(input logic [7:0] v);
        irq_n = 0;
        op_done <= 1'b1;
        meas_result <= v;
        @(posedge hclk);
        op_done <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("irq count", 1, irq_n);
        chk("busy", 0, busy);
    endtask : done

    task automatic finish_test;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test

    initial begin
        repeat (5000) @(posedge hclk);
        num_errors++;
        finish_test;
    end

    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, op_done, meas_result} = '0;
        hsize = 3'b010;
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd("ctrl", OFS_CTRL, 32'h0);
        ahb(OFS_STATUS, 1'b1, 32'hff);
        rd("status", OFS_STATUS, 32'h0);
        rd("unmapped", 8'h10, 32'h0);
        $display("test reset done");
        run(6'h04, -1);
        run(6'h02, -1);
        rd("status rej", OFS_STATUS, 32'h1);
        run(6'h10, 10);
        chk("rx_masked", 1, rx_masked);
        run(6'h11, 11);
        run(6'h0a, -1);
        rd("lastcmd", OFS_LASTCMD, 32'hd1);
        $display("test enables done");
        ahb(OFS_CTRL, 1'b1, 32'h0f);
        for (int i = 0; i < 15; i++) run(cc[i], ca[i]);
        chk("am_on", 1, am_on);
        chk("tgt_sleep", 1, tgt_sleep);
        chk("transparent", 1, transparent);
        $display("test table done");
        seen.delete();
        i_rfdc_host.frame(6'h05, 6'h11, 1'b1);
        repeat (8) @(posedge hclk);
        chk("chain count", 2, seen.size());
        seen.delete();
        i_rfdc_host.frame(6'h18, 6'h04, 1'b1);
        repeat (8) @(posedge hclk);
        chk("no chain count", 1, seen.size());
        if (seen.size() > 0) chk("no chain act", 32'h4, seen[0]);
        for (int i = 0; i < 2; i++) begin
            seen.delete();
            i_rfdc_host.frame(6'h3b + 6'(i), 6'h3c - 6'(i), 1'b1);
            @(negedge hclk);
            chk("window", 1, i ? test_open : space_b_open);
            repeat (8) @(posedge hclk);
            chk("window shut", 0, space_b_open | test_open);
            chk("window count", 2, seen.size());
        end
        $display("test chaining done");
        for (int i = 0; i < 5; i++) begin
            run(lc[i], la[i]);
            chk("busy", 1, busy);
            if (i == 0) run(6'h04, -1);
            done(8'h30 + 8'(i));
            if (i == 2) rd("adc", OFS_ADC, 32'h32);
        end
        $display("test long done");
        run(6'h00, 0);
        rd("ctrl", OFS_CTRL, 32'h0);
        ahb(OFS_CTRL, 1'b1, 32'h01);
        run(6'h01, 0);
        rd("ctrl", OFS_CTRL, 32'h0);
        $display("test default done");
        finish_test;
    end
endmodule : rfdc_top_test
